// *** hw/io_ports_pkg.sv ***
// Purpose: Constants and types for the bidirectional I/O port block
// Assumes: One access per instruction cycle, issued by the CPU core
// Notes: Latch reset value is a free choice; pins read live anyway
// Contract
// - Port reads return live pin levels, never the output latches.
// - Reset sets every direction bit to one: all pins are inputs.
// - Port A has pins on bits 3..0; bits 7..4 read zero.
// - Port B has eight individually controllable pins.
// - Port C is pins on mid and large variants, storage on smallest.
// - Port D is pins only on the largest variant, storage otherwise.
// - Port E pins on bits 7..4 on largest variant; else storage.
// - Direction-load copies the whole working register into direction.
// - Direction one tristates the pin; zero drives the latch bit.
// - Direction registers are write-only and cannot be read back.
// - Output latches keep the last written value until next write.
// - Every pin direction is set independently by its own bit.
// - Bit set or clear reads pins, modifies bit, writes all latches.
// - Read-modify-write copies input pin levels into their latches.
// - Writes land at cycle end; reads sample pins at cycle start.
package io_ports_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_PORT_A = 5'h05;
    localparam logic [4:0] ADDR_PORT_B = 5'h06;
    localparam logic [4:0] ADDR_PORT_C = 5'h07;
    localparam logic [4:0] ADDR_PORT_D = 5'h08;
    localparam logic [4:0] ADDR_PORT_E = 5'h09;
    localparam int NUM_PORTS = 5;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] MASK_A = 8'h0f;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_E = 8'hf0;

    // ------------------------------------------------------------
    // Variants and operations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VARIANT_SMALL = 2'h0,
        VARIANT_MID = 2'h1,
        VARIANT_LARGE = 2'h3
    } variant_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_READ = 3'h1,
        OP_WRITE = 3'h3,
        OP_BIT_SET = 3'h2,
        OP_BIT_CLEAR = 3'h6,
        OP_DIR_LOAD = 3'h7
    } op_t;

    typedef struct packed {
        op_t op;
        logic [4:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } cpu_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [7:0] data;
    } cpu_rsp_t;

endpackage

// *** hw/io_ports.sv ***
// Purpose: Five file-addressed bidirectional ports with direction regs
// Assumes: Pin inputs synchronous to i_clk; one request per cycle
// Notes: Read data answers one cycle after the request
`timescale 1ns/100ps
module io_ports
    import io_ports_pkg::*;
#(
    parameter variant_t VARIANT = VARIANT_LARGE
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // CPU side
    input wire cpu_req_t i_req,
    output cpu_rsp_t o_rsp,
    // Pins
    input wire logic [39:0] i_pin,
    output logic [39:0] o_pin,
    output logic [39:0] o_pin_oe
);

    initial begin
        if (VARIANT != VARIANT_SMALL && VARIANT != VARIANT_MID &&
            VARIANT != VARIANT_LARGE) begin
            $error("io_ports: unsupported variant");
        end
    end

    // ------------------------------------------------------------
    // Port configuration
    // ------------------------------------------------------------
    // Implemented pin mask per port; zero means storage register
    function automatic logic [7:0] pin_mask(input int idx);
        logic [7:0] m;
        m = 8'h00;
        case (idx)
            0: m = MASK_A;
            1: m = MASK_FULL;
            2: m = (VARIANT != VARIANT_SMALL) ? MASK_FULL : 8'h00;
            3: m = (VARIANT == VARIANT_LARGE) ? MASK_FULL : 8'h00;
            4: m = (VARIANT == VARIANT_LARGE) ? MASK_E : 8'h00;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    function automatic int port_index(input logic [4:0] addr);
        int i;
        i = -1;
        if (addr == ADDR_PORT_A) begin
            i = 0;
        end else if (addr == ADDR_PORT_B) begin
            i = 1;
        end else if (addr == ADDR_PORT_C) begin
            i = 2;
        end else if (addr == ADDR_PORT_D) begin
            i = 3;
        end else if (addr == ADDR_PORT_E) begin
            i = 4;
        end
        return i;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] latch [NUM_PORTS];
    logic [7:0] dir [NUM_PORTS];
    logic [7:0] store [NUM_PORTS];
    logic [7:0] next_latch [NUM_PORTS];
    logic [7:0] next_dir [NUM_PORTS];
    logic [7:0] next_store [NUM_PORTS];
    cpu_rsp_t next_rsp;
    logic [39:0] next_pin;
    logic [39:0] next_pin_oe;

    always_comb begin
        int idx;
        logic [7:0] m;
        logic [7:0] cur;
        logic [7:0] res;
        idx = port_index(i_req.addr);
        m = 8'h00;
        cur = 8'h00;
        res = 8'h00;
        next_rsp = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_latch[p] = latch[p];
            next_dir[p] = dir[p];
            next_store[p] = store[p];
        end
        if (idx >= 0 && i_req.op != OP_NONE) begin
            m = pin_mask(idx);
            // Pins sampled now, at the start of the cycle
            if (m != 8'h00) begin
                cur = i_pin[idx*8 +: 8] & m;
            end else begin
                cur = store[idx];
            end
            res = i_req.wdata;
            if (i_req.op == OP_BIT_SET) begin
                res = cur | (8'h01 << i_req.bit_sel);
            end else if (i_req.op == OP_BIT_CLEAR) begin
                res = cur & ~(8'h01 << i_req.bit_sel);
            end
            next_rsp.valid = 1'b1;
            next_rsp.hit = 1'b1;
            // Direction regs are write-only: nothing is returned
            if (i_req.op == OP_READ || i_req.op == OP_BIT_SET ||
                i_req.op == OP_BIT_CLEAR) begin
                next_rsp.data = cur;
            end
            if (i_req.op == OP_WRITE || i_req.op == OP_BIT_SET ||
                i_req.op == OP_BIT_CLEAR) begin
                // On bit set/clear, input-mode latch bits pick up the sampled pin level; a write loads wdata
                if (m != 8'h00) begin
                    next_latch[idx] = res & m;
                end else begin
                    next_store[idx] = res;
                end
            end
            if (i_req.op == OP_DIR_LOAD && m != 8'h00) begin
                next_dir[idx] = i_req.wdata;
            end
        end else if (i_req.op != OP_NONE) begin
            next_rsp.valid = 1'b1;
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            m = pin_mask(p);
            // One tristates, zero drives the latch
            next_pin[p*8 +: 8] = next_latch[p] & m;
            next_pin_oe[p*8 +: 8] = ~next_dir[p] & m;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                dir[p] <= DIR_RESET;
                latch[p] <= LATCH_RESET;
                store[p] <= LATCH_RESET;
            end
            o_rsp <= '0;
            o_pin <= '0;
            o_pin_oe <= '0;
        end else begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                dir[p] <= next_dir[p];
                latch[p] <= next_latch[p];
                store[p] <= next_store[p];
            end
            o_rsp <= next_rsp;
            o_pin <= next_pin;
            o_pin_oe <= next_pin_oe;
        end
    end

endmodule

// *** verif/pin_partner.sv ***
// Purpose: External circuitry on the port pins
// Assumes: i_frc marks pins that are held against the driver
// Notes: Undriven pins show the external level
`timescale 1ns/100ps
module pin_partner (
    input wire logic [39:0] i_drv,
    input wire logic [39:0] i_oe,
    input wire logic [39:0] i_ext,
    input wire logic [39:0] i_frc,
    output logic [39:0] o_lvl
);
    // Owned pins follow the driver; others stay put until the bench changes them
    wire logic [39:0] own = i_oe & ~i_frc;
    assign o_lvl = (own & i_drv) | (~own & i_ext);
endmodule

// *** verif/io_ports_props.sv ***
// Purpose: Port-level checks of the I/O port block
// Assumes: Large variant; one request per cycle
// Notes: Bound into every io_ports instance
`timescale 1ns/100ps
module io_ports_props
    import io_ports_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire cpu_req_t i_req,
    input wire cpu_rsp_t o_rsp,
    input wire logic [39:0] i_pin,
    input wire logic [39:0] o_pin,
    input wire logic [39:0] o_pin_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire op_t op = i_req.op;
    wire logic [4:0] ad = i_req.addr;
    rsp_pulse_a: assert property (op != OP_NONE |=> o_rsp.valid)
        else $error("no response");
    idle_quiet_a: assert property (op == OP_NONE |=> !o_rsp.valid)
        else $error("stray response");
    live_read_a: assert property (op == OP_READ && ad == ADDR_PORT_B
        |=> o_rsp.data == $past(i_pin[15:8])) else $error("read b");
    upper_zero_a: assert property (op == OP_READ && ad == ADDR_PORT_A
        |=> o_rsp.data == ($past(i_pin[7:0]) & MASK_A)) else $error("read a");
    dir_copy_a: assert property (op == OP_DIR_LOAD && ad == ADDR_PORT_B
        |=> o_pin_oe[15:8] == ~$past(i_req.wdata)) else $error("dir b");
    dir_blind_a: assert property (op == OP_DIR_LOAD
        |=> o_rsp.data == 8'h00) else $error("dir readback");
    reset_input_a: assert property (disable iff (1'b0) !i_nrst
        |=> o_pin_oe == 40'h0) else $error("reset drive");
    latch_hold_a: assert property (op inside {OP_NONE, OP_READ}
        |=> $stable(o_pin)) else $error("latch moved");
    write_mask_a: assert property (op == OP_WRITE && ad == ADDR_PORT_A
        |=> o_pin[7:0] == ($past(i_req.wdata) & MASK_A)) else $error("wr a");
    rmw_merge_a: assert property (op == OP_BIT_CLEAR && ad == ADDR_PORT_B
        |=> o_pin[15:8] == ($past(i_pin[15:8])
        & ~(8'h01 << $past(i_req.bit_sel)))) else $error("rmw b");
    cover property (op == OP_BIT_CLEAR);
    cover property (op == OP_DIR_LOAD);
    cover property (op == OP_WRITE ##2 op == OP_READ);
endmodule
bind io_ports io_ports_props i_io_ports_props (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_req(i_req), .o_rsp(o_rsp), .i_pin(i_pin),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe));

// *** verif/tb_io_ports.sv ***
// Purpose: Directed bench for the I/O port block
// Assumes: Large variant; inputs change at the falling edge
// Notes: One idle cycle separates requests
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    error_cnt++; $display("[FAIL] %0t value mismatch", $time); end end
module tb_io_ports
    import io_ports_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    cpu_req_t i_req = 19'h0;
    cpu_rsp_t o_rsp;
    logic [39:0] i_pin, o_pin, o_pin_oe;
    logic [39:0] ext = 40'h0;
    logic [39:0] frc = 40'h0;
    int error_cnt = 0;
    int tests_run = 0;
    always #2 i_clk = ~i_clk;
    io_ports i_io_ports (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req),
        .o_rsp(o_rsp), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe));
    pin_partner i_pin_partner (.i_drv(o_pin), .i_oe(o_pin_oe),
        .i_ext(ext), .i_frc(frc), .o_lvl(i_pin));
    // Response is looked at in the cycle after the taking edge
    task automatic acc(input op_t o, input logic [4:0] a,
        input logic [2:0] b, input logic [7:0] w);
        @(negedge i_clk);
        i_req <= '{o, a, b, w};
        @(negedge i_clk);
        i_req.op <= OP_NONE;
        `CHK(o_rsp.valid, 1'b1)
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge i_clk);
        `CHK(o_pin_oe, 40'h0)
        i_nrst <= 1'b1;
        ext <= 40'h5c0000a5ff;
        acc(OP_READ, ADDR_PORT_B, 3'h0, 8'h00);
        `CHK(o_rsp.data, 8'ha5)
        acc(OP_READ, ADDR_PORT_A, 3'h0, 8'h00);
        `CHK(o_rsp.data, 8'h0f)
        acc(OP_WRITE, ADDR_PORT_A, 3'h0, 8'h5a);
        `CHK(o_pin[7:0], 8'h0a)
        acc(OP_WRITE, ADDR_PORT_E, 3'h0, 8'hab);
        `CHK(o_pin[39:32], 8'ha0)
        acc(OP_READ, ADDR_PORT_E, 3'h0, 8'h00);
        `CHK(o_rsp.data, 8'h50)
        $display("test reset_and_masks done");
        acc(OP_WRITE, ADDR_PORT_B, 3'h0, 8'h33);
        acc(OP_DIR_LOAD, ADDR_PORT_B, 3'h0, 8'hf0);
        `CHK(o_rsp.data, 8'h00)
        `CHK(o_pin_oe[15:8], 8'h0f)
        ext[15:8] <= 8'hc0;
        frc[15:8] <= 8'h01;
        acc(OP_READ, ADDR_PORT_B, 3'h0, 8'h00);
        `CHK(o_rsp.data, 8'hc2)
        acc(OP_BIT_CLEAR, ADDR_PORT_B, 3'h1, 8'h00);
        `CHK(o_rsp.data, 8'hc2)
        `CHK(o_pin[15:8], 8'hc0)
        acc(OP_DIR_LOAD, ADDR_PORT_B, 3'h0, 8'hff);
        `CHK(o_pin[15:8], 8'hc0)
        `CHK(o_pin_oe[15:8], 8'h00)
        acc(OP_READ, 5'h1f, 3'h0, 8'h00);
        `CHK(o_rsp.hit, 1'b0)
        $display("test direction_and_rmw done");
        acc(OP_WRITE, ADDR_PORT_D, 3'h0, 8'h96);
        acc(OP_DIR_LOAD, ADDR_PORT_D, 3'h0, 8'h00);
        `CHK(o_pin_oe[31:24], 8'hff)
        acc(OP_READ, ADDR_PORT_D, 3'h0, 8'h00);
        `CHK(o_rsp.data, 8'h96)
        acc(OP_WRITE, ADDR_PORT_C, 3'h0, 8'h3c);
        `CHK(o_pin[23:16], 8'h3c)
        // Second reset in mid-run must float every pin again
        @(negedge i_clk);
        i_nrst <= 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK(o_pin_oe, 40'h0)
        `CHK(o_pin, 40'h0)
        i_nrst <= 1'b1;
        $display("test ports_c_d_and_reset done");
        final_report();
    end
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule
